// ### ssp_consts.svh
// Constants for the synchronous serial port
// Overview of operation
// - SPI mode shifts eight bits out and in together, all four clock modes.
// - Inputs select master or slave, idle level, sample phase, clock edge, rate, select use.
// - A slave may use the select input to qualify transfers from the master.
// - The shift register moves data most significant bit first, both directions.
// - A received byte goes to the buffer, setting full and interrupt flags.
// - A buffer write while shifting is dropped and sets the sticky collision flag.
// - Reading the buffer clears the full flag.
// - I2C baud generator loads seven reload bits, counts to zero, then halts.
// - The baud count decrements on phase two and phase four of each cycle.
// - The state machine reloads the baud generator; during stretching it reloads every cycle until clock high.
// - An I2C buffer write sets full and starts the baud generator and transmission.
// - Data changes after clock falls; clock low one period, then released one period.
// - At the eighth falling edge full clears and the data line is released.
// - At the ninth falling edge the data line is sampled into the acknowledge status.
// - After the ninth clock interrupt sets; clock held low until the next write or a STOP.
// - An address byte is seven address bits then direction bit, then acknowledge.
// - The stop enable bit makes a STOP condition, then raises the interrupt flag.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_BYTE_W 8
`define SSP_RELOAD_W 7
`define SSP_PIN_W 4
`define SSP_CNT_W 5
`define SSP_SPI_EDGES 5'h10
`define SSP_I2C_ACK_BIT 5'h08
`define SSP_I2C_LAST_BIT 5'h09
`define SSP_HALF_BASE 8'h02
`define SSP_Q2_PHASE 2'h1
`define SSP_Q4_PHASE 2'h3
`endif

// ### ssp_pkg.sv
// Types of the synchronous serial port
package ssp_pkg;
    typedef struct packed {
        logic modeI2c;
        logic spiMaster;
        logic clkIdleHigh;
        logic sampleEnd;
        logic txOnActiveToIdle;
        logic [1:0] masterRate;
        logic slaveSelectEn;
    } ssp_cfg_type;

    typedef struct packed {
        logic sck;
        logic sdi;
        logic ssn;
        logic sda;
    } ssp_pins_type;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LOW = 7'h02,
        ST_HIGH = 7'h04,
        ST_HOLD = 7'h08,
        ST_STOP_LOW = 7'h10,
        ST_STOP_SCL = 7'h20,
        ST_STOP_SDA = 7'h40
    } ssp_i2c_state_type;
endpackage

// ### ssp_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ssp_sync2 #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= asyncIn;
            sync_r <= meta_r;
        end
    end

    assign syncOut = sync_r;
endmodule

// ### ssp_baud_gen.sv
// Down-counting baud generator with reload
`include "ssp_consts.svh"
`timescale 1ns/10ps
module ssp_baud_gen
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic load,
    input wire logic [`SSP_RELOAD_W-1:0] reloadVal,
    input wire logic tick,
    output logic zero
);
    logic [`SSP_RELOAD_W-1:0] count_r;
    logic [`SSP_RELOAD_W-1:0] count_nxt;

    always_comb
    begin
        count_nxt = count_r;
        if (load)
            count_nxt = reloadVal;
        else if (tick && count_r != '0)
            count_nxt = count_r - `SSP_RELOAD_W'(1);
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            count_r <= '0;
        else
            count_r <= count_nxt;
    end

    assign zero = (count_r == '0);

    a_baud_reload: assert property (@(posedge sys_clk) disable iff (!resetn)
        load |=> count_r == $past(reloadVal))
        else $error("baud generator did not take the reload value");
    a_baud_halts: assert property (@(posedge sys_clk) disable iff (!resetn)
        zero && !load |=> zero)
        else $error("baud generator left zero without a reload");
    a_baud_tick_dec: assert property (@(posedge sys_clk) disable iff (!resetn)
        !load && !zero |=> count_r == $past(count_r) - $past(tick))
        else $error("baud generator decrement does not follow the phase tick");
endmodule

// ### ssp_port.sv
// Synchronous serial port: SPI master or slave, I2C master transmitter
`include "ssp_consts.svh"
`timescale 1ns/10ps
module ssp_port
    import ssp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire ssp_cfg_type cfg,
    input wire logic [`SSP_BYTE_W-1:0] addrReload,
    input wire logic bufWrite,
    input wire logic [`SSP_BYTE_W-1:0] bufWrData,
    input wire logic bufRead,
    output logic [`SSP_BYTE_W-1:0] bufRdData,
    output logic bufferFull,
    output logic irqFlag,
    input wire logic irqClear,
    output logic writeCollision,
    input wire logic wcolClear,
    output logic ackStatus,
    input wire logic stopEnable,
    output logic stopBusy,
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    input wire logic sdiIn,
    output logic sdoOut,
    output logic sdoOe,
    input wire logic ssnIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    ssp_pins_type pinsAsync;
    ssp_pins_type pins;
    logic [1:0] qPhase_r;
    logic [1:0] qPhase_nxt;
    logic baudTick;
    logic baudLoad;
    logic baudZero;
    logic [`SSP_BYTE_W-1:0] sr_r, sr_nxt;
    logic [`SSP_BYTE_W-1:0] buf_r, buf_nxt;
    logic full_r, full_nxt;
    logic irq_r, irq_nxt;
    logic write_collision_flag_r, write_collision_flag_nxt;
    logic ack_r, ack_nxt;
    logic stop_r, stop_nxt;
    logic [`SSP_CNT_W-1:0] cnt_r, cnt_nxt;
    logic txBit_r, txBit_nxt;
    logic sck_r, sck_nxt;
    logic sckPrev_r, sckPrev_nxt;
    logic [`SSP_BYTE_W-1:0] half_r, half_nxt;
    logic spiBusy_r, spiBusy_nxt;
    ssp_i2c_state_type st_r, st_nxt;
    logic sclDrv_r, sclDrv_nxt;
    logic sdaDrv_r, sdaDrv_nxt;
    logic [`SSP_BYTE_W-1:0] halfLen;
    logic spiEdge, spiLead, spiTrail, midEdge, outEdge, capEdge;
    logic slaveBlocked, shifting, spiDone, i2cFall;
    logic [`SSP_CNT_W-1:0] cntInc;

    assign pinsAsync = '{sck: sckIn, sdi: sdiIn, ssn: ssnIn, sda: sdaIn};

    ssp_sync2 #(.W(`SSP_PIN_W)) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .asyncIn(pinsAsync),
        .syncOut(pins)
    );

    ssp_baud_gen u_baud (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .load(baudLoad),
        .reloadVal(addrReload[`SSP_RELOAD_W-1:0]),
        .tick(baudTick),
        .zero(baudZero)
    );

    // Instruction cycle phases, the baud count steps on two of the four
    assign qPhase_nxt = qPhase_r + 2'h1;
    assign baudTick = (qPhase_r == `SSP_Q2_PHASE) || (qPhase_r == `SSP_Q4_PHASE);

    // SPI clock edge decoding, master from its own clock, slave from the pin
    assign halfLen = `SSP_HALF_BASE << {cfg.masterRate, 1'b0};
    assign slaveBlocked = !cfg.spiMaster && cfg.slaveSelectEn && pins.ssn;
    assign spiEdge = cfg.spiMaster ? (spiBusy_r && half_r == `SSP_BYTE_W'(1))
                                   : (!slaveBlocked && pins.sck != sckPrev_r);
    assign spiLead = spiEdge && (cfg.spiMaster ? (sck_r == cfg.clkIdleHigh)
                                               : (pins.sck != cfg.clkIdleHigh));
    assign spiTrail = spiEdge && !spiLead;
    assign midEdge = cfg.txOnActiveToIdle ? spiLead : spiTrail;
    assign outEdge = cfg.txOnActiveToIdle ? spiTrail : spiLead;
    assign capEdge = (cfg.sampleEnd && cfg.spiMaster) ? outEdge : midEdge;
    assign cntInc = cnt_r + `SSP_CNT_W'(1);
    assign spiDone = !cfg.modeI2c && spiEdge && cntInc == `SSP_SPI_EDGES;
    assign i2cFall = cfg.modeI2c && st_r == ST_HIGH && pins.sck && baudZero;
    assign shifting = cfg.modeI2c ? (st_r != ST_IDLE && st_r != ST_HOLD)
                                  : (cfg.spiMaster ? spiBusy_r : cnt_r != '0);

    always_comb
    begin
        sr_nxt = sr_r;
        buf_nxt = buf_r;
        full_nxt = full_r;
        irq_nxt = irq_r;
        write_collision_flag_nxt = write_collision_flag_r;
        ack_nxt = ack_r;
        stop_nxt = stop_r;
        cnt_nxt = cnt_r;
        txBit_nxt = txBit_r;
        sck_nxt = sck_r;
        sckPrev_nxt = pins.sck;
        half_nxt = half_r;
        spiBusy_nxt = spiBusy_r;
        st_nxt = st_r;
        sclDrv_nxt = sclDrv_r;
        sdaDrv_nxt = sdaDrv_r;
        baudLoad = 1'b0;

        // Software clears first so that a hardware set in the same cycle wins
        if (bufRead)
            full_nxt = 1'b0;
        if (irqClear)
            irq_nxt = 1'b0;
        if (wcolClear)
            write_collision_flag_nxt = 1'b0;
        if (stopEnable)
            stop_nxt = 1'b1;

        if (bufWrite && shifting)
            write_collision_flag_nxt = 1'b1;

        if (!cfg.modeI2c)
        begin
            sclDrv_nxt = 1'b0;
            sdaDrv_nxt = 1'b0;
            st_nxt = ST_IDLE;
            if (!spiBusy_r)
                sck_nxt = cfg.clkIdleHigh;
            if (slaveBlocked)
                cnt_nxt = '0;
            if (bufWrite && !shifting)
            begin
                sr_nxt = bufWrData;
                buf_nxt = bufWrData;
                txBit_nxt = bufWrData[`SSP_BYTE_W-1];
                cnt_nxt = '0;
                spiBusy_nxt = cfg.spiMaster;
                half_nxt = halfLen;
            end
            else
            begin
                if (spiBusy_r)
                    half_nxt = (half_r == `SSP_BYTE_W'(1)) ? halfLen : half_r - `SSP_BYTE_W'(1);
                if (spiEdge)
                begin
                    cnt_nxt = cntInc;
                    if (cfg.spiMaster)
                        sck_nxt = !sck_r;
                    if (capEdge)
                        sr_nxt = {sr_r[`SSP_BYTE_W-2:0], pins.sdi};
                    if (outEdge)
                        txBit_nxt = sr_nxt[`SSP_BYTE_W-1];
                end
                if (spiDone)
                begin
                    buf_nxt = sr_nxt;
                    full_nxt = 1'b1;
                    irq_nxt = 1'b1;
                    cnt_nxt = '0;
                    spiBusy_nxt = 1'b0;
                end
            end
        end
        else
        begin
            spiBusy_nxt = 1'b0;
            cnt_nxt = cnt_r;
            unique case (st_r)
                ST_IDLE, ST_HOLD:
                begin
                    sclDrv_nxt = (st_r == ST_HOLD);
                    if (bufWrite)
                    begin
                        sr_nxt = bufWrData;
                        buf_nxt = bufWrData;
                        full_nxt = 1'b1;
                        cnt_nxt = '0;
                        st_nxt = ST_LOW;
                        sclDrv_nxt = 1'b1;
                        sdaDrv_nxt = !bufWrData[`SSP_BYTE_W-1];
                        baudLoad = 1'b1;
                    end
                    else if (st_r == ST_HOLD && stop_r)
                    begin
                        st_nxt = ST_STOP_LOW;
                        sdaDrv_nxt = 1'b1;
                        baudLoad = 1'b1;
                    end
                end
                ST_LOW:
                begin
                    if (baudZero)
                    begin
                        st_nxt = ST_HIGH;
                        sclDrv_nxt = 1'b0;
                        baudLoad = 1'b1;
                    end
                end
                ST_HIGH:
                begin
                    if (!pins.sck)
                        baudLoad = 1'b1;
                    else if (baudZero)
                    begin
                        sclDrv_nxt = 1'b1;
                        cnt_nxt = cntInc;
                        if (cntInc < `SSP_I2C_ACK_BIT)
                        begin
                            sr_nxt = {sr_r[`SSP_BYTE_W-2:0], 1'b0};
                            sdaDrv_nxt = !sr_r[`SSP_BYTE_W-2];
                            st_nxt = ST_LOW;
                            baudLoad = 1'b1;
                        end
                        else if (cntInc == `SSP_I2C_ACK_BIT)
                        begin
                            sdaDrv_nxt = 1'b0;
                            full_nxt = 1'b0;
                            st_nxt = ST_LOW;
                            baudLoad = 1'b1;
                        end
                        else
                        begin
                            ack_nxt = pins.sda;
                            irq_nxt = 1'b1;
                            st_nxt = ST_HOLD;
                        end
                    end
                end
                ST_STOP_LOW:
                begin
                    if (baudZero)
                    begin
                        st_nxt = ST_STOP_SCL;
                        sclDrv_nxt = 1'b0;
                        baudLoad = 1'b1;
                    end
                end
                ST_STOP_SCL:
                begin
                    if (!pins.sck)
                        baudLoad = 1'b1;
                    else if (baudZero)
                    begin
                        st_nxt = ST_STOP_SDA;
                        sdaDrv_nxt = 1'b0;
                        baudLoad = 1'b1;
                    end
                end
                ST_STOP_SDA:
                begin
                    if (baudZero)
                    begin
                        st_nxt = ST_IDLE;
                        stop_nxt = stopEnable;
                        irq_nxt = 1'b1;
                    end
                end
                default:
                begin
                    st_nxt = ST_IDLE;
                    sclDrv_nxt = 1'b0;
                    sdaDrv_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            qPhase_r <= 2'h0;
            sr_r <= 8'h00;
            buf_r <= 8'h00;
            full_r <= 1'b0;
            irq_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            ack_r <= 1'b0;
            stop_r <= 1'b0;
            cnt_r <= 5'h00;
            txBit_r <= 1'b0;
            sck_r <= 1'b0;
            sckPrev_r <= 1'b0;
            half_r <= 8'h00;
            spiBusy_r <= 1'b0;
            st_r <= ST_IDLE;
            sclDrv_r <= 1'b0;
            sdaDrv_r <= 1'b0;
        end
        else
        begin
            qPhase_r <= qPhase_nxt;
            sr_r <= sr_nxt;
            buf_r <= buf_nxt;
            full_r <= full_nxt;
            irq_r <= irq_nxt;
            write_collision_flag_r <= write_collision_flag_nxt;
            ack_r <= ack_nxt;
            stop_r <= stop_nxt;
            cnt_r <= cnt_nxt;
            txBit_r <= txBit_nxt;
            sck_r <= sck_nxt;
            sckPrev_r <= sckPrev_nxt;
            half_r <= half_nxt;
            spiBusy_r <= spiBusy_nxt;
            st_r <= st_nxt;
            sclDrv_r <= sclDrv_nxt;
            sdaDrv_r <= sdaDrv_nxt;
        end
    end

    assign bufRdData = buf_r;
    assign bufferFull = full_r;
    assign irqFlag = irq_r;
    assign writeCollision = write_collision_flag_r;
    assign ackStatus = ack_r;
    assign stopBusy = stop_r;
    // Open-drain lines in I2C mode: output level is always low
    assign sckOut = cfg.modeI2c ? 1'b0 : sck_r;
    assign sckOe = cfg.modeI2c ? sclDrv_r : cfg.spiMaster;
    assign sdoOut = txBit_r;
    assign sdoOe = !cfg.modeI2c && !slaveBlocked;
    assign sdaOut = 1'b0;
    assign sdaOe = cfg.modeI2c && sdaDrv_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_ninth_fall;
        i2cFall && cntInc == `SSP_I2C_LAST_BIT;
    endsequence
    sequence s_eighth_fall;
        i2cFall && cntInc == `SSP_I2C_ACK_BIT;
    endsequence

    a_write_collision_flag_busy_write: assert property (bufWrite && shifting |=> writeCollision)
        else $error("write during shifting did not set the collision flag");
    a_write_collision_flag_buffer_kept: assert property (bufWrite && shifting && !spiDone
        |=> bufRdData == $past(bufRdData))
        else $error("write during shifting changed the buffer");
    a_read_clears_full: assert property (bufRead && !spiDone
        && !(cfg.modeI2c && bufWrite && !shifting) |=> !bufferFull)
        else $error("buffer read did not clear the full flag");
    a_spi_byte_done: assert property (spiDone |=> bufferFull && irqFlag
        && bufRdData == $past(sr_nxt))
        else $error("received byte not moved to the buffer with flags");
    a_i2c_write_start: assert property (cfg.modeI2c && bufWrite && !shifting
        |=> bufferFull && st_r == ST_LOW && sckOe)
        else $error("I2C write did not start a transmission");
    a_i2c_eighth_release: assert property (s_eighth_fall |=> !sdaOe && !bufferFull
        ##1 !sdaOe)
        else $error("data line not released after the eighth clock");
    a_i2c_ninth_ack: assert property (s_ninth_fall |=> ackStatus == $past(pins.sda)
        && irqFlag && st_r == ST_HOLD)
        else $error("acknowledge not captured at the ninth falling edge");
    a_i2c_hold_low: assert property (st_r == ST_HOLD && !bufWrite && !stop_r
        |=> sckOe && st_r == ST_HOLD)
        else $error("clock not held low while suspended");
    a_i2c_stretch: assert property (cfg.modeI2c && st_r == ST_HIGH && !pins.sck
        |=> st_r == ST_HIGH)
        else $error("clock high phase ended while the line was held low");
    a_i2c_no_drive_high: assert property (cfg.modeI2c |-> !sckOut && !sdaOut)
        else $error("I2C line driven high");
endmodule

// ### ssp_peer.sv
// Far-side model: SPI peer and I2C slave receiver
`timescale 1ns/10ps
module ssp_peer (
    input wire logic sck,
    input wire logic sdo,
    input wire logic scl,
    input wire logic sda,
    input wire logic arm,
    input wire logic ackEn,
    input wire logic [7:0] txByte,
    output logic sdi,
    output logic sdaPull,
    output logic [7:0] rxByte,
    output logic [7:0] i2cByte
);
    int spiCnt;
    int riseCnt;
    initial
    begin
        spiCnt = 0;
        riseCnt = 0;
        sdaPull = 1'b0;
    end
    always @(posedge arm)
    begin
        spiCnt = 0;
        riseCnt = 0;
        sdaPull = 1'b0;
    end
    // Idle data line drives the inverse of the port data output instead of holding the last bit
    assign sdi = (spiCnt < 8) ? txByte[7 - spiCnt] : ~sdo;
    always @(posedge sck)
        rxByte <= {rxByte[6:0], sdo};
    always @(negedge sck)
        spiCnt++;
    always @(posedge scl)
    begin
        if (riseCnt < 8)
            i2cByte <= {i2cByte[6:0], sda};
        riseCnt++;
    end
    always @(negedge scl)
        sdaPull <= ackEn && (riseCnt == 8);
endmodule

// ### test_ssp_port.sv
// Testbench of the synchronous serial port
`timescale 1ns/10ps
module test_ssp_port;
    import ssp_pkg::*;
    logic sys_clk, resetn, bufWrite, bufRead, irqClear, wcolClear, stopEnable, arm, ackEn, ssn;
    logic bufferFull, irqFlag, writeCollision, ackStatus, stopBusy;
    logic sckOut, sckOe, sdoOut, sdoOe, sdaOut, sdaOe, sdi, sdaPull;
    logic [7:0] addrReload, bufWrData, bufRdData, peerTx, peerRx, peerI2c;
    ssp_cfg_type cfg;
    wire sckLine = cfg.modeI2c ? !(sckOe && !sckOut) : (sckOe ? sckOut : 1'b0);
    wire sdaLine = !((sdaOe && !sdaOut) || sdaPull);
    int err_total = 0;
    int compares = 0;
    ssp_port uut (.sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .addrReload(addrReload),
        .bufWrite(bufWrite), .bufWrData(bufWrData), .bufRead(bufRead), .bufRdData(bufRdData),
        .bufferFull(bufferFull), .irqFlag(irqFlag), .irqClear(irqClear),
        .writeCollision(writeCollision), .wcolClear(wcolClear), .ackStatus(ackStatus),
        .stopEnable(stopEnable), .stopBusy(stopBusy), .sckIn(sckLine), .sckOut(sckOut),
        .sckOe(sckOe), .sdiIn(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .ssnIn(ssn),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
    ssp_peer peer (.sck(sckLine), .sdo(sdoOut), .scl(sckLine), .sda(sdaLine), .arm(arm),
        .ackEn(ackEn), .txByte(peerTx), .sdi(sdi), .sdaPull(sdaPull), .rxByte(peerRx),
        .i2cByte(peerI2c));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(input int which);
        bufRead = (which == 0);
        irqClear = (which == 1);
        wcolClear = (which == 2);
        stopEnable = (which == 3);
        arm = (which == 4);
        tick();
        {bufRead, irqClear, wcolClear, stopEnable, arm} = 5'h00;
    endtask
    task automatic swWrite(input logic [7:0] d);
        bufWrData = d;
        bufWrite = 1'b1;
        tick();
        bufWrite = 1'b0;
    endtask
    task automatic waitSig(input int which, input logic lvl);
        int i;
        for (i = 0; i < 20000 && ((which == 0 ? irqFlag : stopBusy) !== lvl); i++)
            tick();
        if (i == 20000)
        begin
            err_total++;
            $display("[ERR] %0t wait bound reached", $time);
            test_done();
        end
    endtask
    task automatic doReset();
        resetn = 1'b0;
        repeat (5) tick();
        resetn = 1'b1;
        repeat (3) tick();
    endtask
    task automatic i2cSend(input logic [7:0] d, input logic ack);
        ackEn = ack;
        pulse(4);
        pulse(1);
        swWrite(d);
        tick();
        check(bufferFull, 1'b1);
        check(sckOut, 1'b0);
        check(sdaOut, 1'b0);
        swWrite(8'h00);
        tick();
        check(writeCollision, 1'b1);
        pulse(2);
        waitSig(0, 1'b1);
        check(peerI2c, d);
        check(ackStatus, !ack);
        check(bufferFull, 1'b0);
        check(sdaOe, 1'b0);
        repeat (40) tick();
        check(sckLine, 1'b0);
    endtask
    initial
    begin
        {bufWrite, bufRead, irqClear, wcolClear, stopEnable, arm, ackEn} = 7'h00;
        ssn = 1'b0;
        bufWrData = 8'h00;
        addrReload = 8'h83;
        peerTx = 8'h3c;
        cfg = '{modeI2c: 1'b0, spiMaster: 1'b1, clkIdleHigh: 1'b0, sampleEnd: 1'b0,
            txOnActiveToIdle: 1'b1, masterRate: 2'h1, slaveSelectEn: 1'b0};
        doReset();
        pulse(4);
        swWrite(8'ha5);
        swWrite(8'hff);
        tick();
        check(writeCollision, 1'b1);
        waitSig(0, 1'b1);
        tick();
        check(bufRdData, 8'h3c);
        check(bufferFull, 1'b1);
        check(peerRx, 8'ha5);
        pulse(0);
        tick();
        check(bufferFull, 1'b0);
        check(writeCollision, 1'b1);
        pulse(2);
        tick();
        check(writeCollision, 1'b0);
        cfg.spiMaster = 1'b0;
        cfg.slaveSelectEn = 1'b1;
        ssn = 1'b1;
        repeat (3) tick();
        check(sdoOe, 1'b0);
        check(sckOe, 1'b0);
        ssn = 1'b0;
        repeat (3) tick();
        check(sdoOe, 1'b1);
        cfg.modeI2c = 1'b1;
        doReset();
        i2cSend(8'ha4, 1'b1);
        i2cSend(8'h3b, 1'b0);
        pulse(1);
        pulse(3);
        waitSig(1, 1'b0);
        tick();
        check(irqFlag, 1'b1);
        check(sdaLine, 1'b1);
        check(sckLine, 1'b1);
        test_done();
    end
endmodule
